// ===== core/ltq_pkg.sv
// package for the logic trigger qualifier: classes, functions, field layouts,
// timing constants. assumes a 100 MHz sample clock.
package ltq_pkg;

  localparam int SYS_CLK_MHZ = 100;
  localparam int CLK_PERIOD_PS = 1000000 / SYS_CLK_MHZ;
  localparam int MIN_WINDOW_PS = 2000;
  // least time rounds up to whole cycles
  localparam int MIN_WINDOW_CYC =
    (MIN_WINDOW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DUR_W = 24;
  localparam int SH_W = 12;
  localparam int CHAN_N = 4;
  localparam logic [1:0] DATA_SRC_RST = 2'h0;
  localparam logic [1:0] CLK_SRC_RST = 2'h1;

  typedef enum logic [1:0] {
    LTQ_CLASS_PATTERN,
    LTQ_CLASS_STATE,
    LTQ_CLASS_SETUP_HOLD
  } ltq_class_type;

  typedef enum logic [1:0] {
    LTQ_FN_AND,
    LTQ_FN_NAND,
    LTQ_FN_OR,
    LTQ_FN_NOR
  } ltq_func_type;

  typedef enum logic [1:0] {
    LTQ_QUAL_NONE,
    LTQ_QUAL_LESS,
    LTQ_QUAL_MORE
  } ltq_qual_type;

  typedef enum logic [1:0] {
    LTQ_PRE_DONT_CARE,
    LTQ_PRE_HIGH,
    LTQ_PRE_LOW
  } ltq_pre_type;

  typedef struct packed {
    ltq_class_type trig_class;
    ltq_func_type func;
    logic goes_false;
    ltq_qual_type qual;
    logic [DUR_W-1:0] dur_limit;
    ltq_pre_type [CHAN_N-1:0] pre;
    logic state_edge_fall;
    logic [1:0] data_src;
    logic [1:0] clk_src;
    logic sh_edge_fall;
  } ltq_cfg_type;

endpackage : ltq_pkg

// ===== core/ltq_sh_window.sv
// setup/hold window limiter: keeps setup plus hold at or above the minimum
// by moving the value not being written. assumes one-cycle write strobes.
`timescale 1ns/1ps
module ltq_sh_window
  import ltq_pkg::*;
#(
  parameter int W = SH_W
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic setup_wr,
  input wire logic hold_wr,
  input wire logic signed [W-1:0] wr_value,
  output logic signed [W-1:0] setup_q,
  output logic signed [W-1:0] hold_q
);

  localparam logic signed [W:0] MIN_SUM = (W+1)'(MIN_WINDOW_CYC);
  localparam logic signed [W-1:0] SETUP_RST = W'(MIN_WINDOW_CYC);
  logic signed [W:0] other_need;

  // the value the untouched side must reach to hold the minimum sum
  always_comb begin
    other_need = MIN_SUM - $signed({wr_value[W-1], wr_value});
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      setup_q <= SETUP_RST;
      hold_q <= '0;
    end else if (setup_wr) begin
      setup_q <= wr_value;
      if ($signed({hold_q[W-1], hold_q}) < other_need) begin
        hold_q <= other_need[W-1:0];
      end
    end else if (hold_wr) begin
      hold_q <= wr_value;
      if ($signed({setup_q[W-1], setup_q}) < other_need) begin
        setup_q <= other_need[W-1:0];
      end
    end
  end

endmodule : ltq_sh_window

// ===== core/ltq_trigger.sv
// logic trigger qualifier: pattern (optionally time qualified), state and
// setup/hold classes over four thresholded probe inputs.
// assumes inputs are synchronous to sys_clk and holdoff is applied by the
// caller through arm; every qualifying event while armed fires.
//
// Functional notes
// - less-than: trigger when true shorter than limit
// - more-than: trigger when true longer than limit
// - time from condition true until false
// - trigger placed where condition went false
// - state class clocks on input four
// - high/low/don't-care preconditions, clock edge choice
// - combining function AND, OR, NAND, NOR
// - trigger on condition met or not met
// - setup/hold: data and clock channel select
// - setup/hold clock edge selectable
// - measure window from clock crossing
// - positive setup before, positive hold after
// - setup plus hold kept at least 2 ns
// - negative setup or hold skews window
// - arm gating common to all classes
// - goes-false swaps AND/NAND and OR/NOR
// - state sampled at clock channel change
// - setup/hold trigger placed at clock edge, or at data time for late data
`timescale 1ns/1ps
module ltq_trigger
  import ltq_pkg::*;
#(
  parameter int DW = DUR_W,
  parameter int SW = SH_W
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic arm,
  input wire ltq_cfg_type cfg,
  input wire logic setup_wr,
  input wire logic hold_wr,
  input wire logic signed [SW-1:0] sh_wr_value,
  input wire logic probe_input_1,
  input wire logic probe_input_2,
  input wire logic probe_input_3,
  input wire logic probe_input_4,
  output logic trig_q,
  output logic [DW-1:0] true_len_q,
  output logic cond_q,
  output logic signed [SW-1:0] setup_out_q,
  output logic signed [SW-1:0] hold_out_q
);

  logic [CHAN_N-1:0] probes;
  logic probes_vld_q;
  logic [CHAN_N-1:0] probes_q;
  logic [CHAN_N-1:0] pre_ok;
  logic [CHAN_N-1:0] pre_used;
  logic any_ok;
  logic all_ok;
  logic cond;
  logic [DW-1:0] timer_q;
  logic timing_q;
  logic cond_prev_q;
  logic state_clk_edge;
  logic signed [SW-1:0] setup_q;
  logic signed [SW-1:0] hold_q;
  logic sh_clk_edge;
  logic data_edge;
  logic [SW-1:0] since_data_q;
  logic [SW-1:0] since_clk_q;
  logic clk_seen_q;
  logic sh_hit;
  logic trig_d;

  assign probes = {probe_input_4, probe_input_3, probe_input_2, probe_input_1};

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      probes_q <= '0;
      probes_vld_q <= 1'b0;
    end else begin
      // no edges until a real previous sample is held
      probes_q <= probes;
      probes_vld_q <= 1'b1;
    end
  end

  // per-channel precondition match
  for (genvar i = 0; i < CHAN_N; i++) begin : g_pre
    always_comb begin
      pre_ok[i] = 1'b0;
      pre_used[i] = 1'b0;
      if (cfg.trig_class == LTQ_CLASS_PATTERN || i < CHAN_N - 1) begin
        unique case (cfg.pre[i])
          LTQ_PRE_HIGH: begin
            pre_used[i] = 1'b1;
            pre_ok[i] = probes[i];
          end
          LTQ_PRE_LOW: begin
            pre_used[i] = 1'b1;
            pre_ok[i] = !probes[i];
          end
          default: begin
            pre_used[i] = 1'b0;
            pre_ok[i] = 1'b0;
          end
        endcase
      end
    end
  end

  always_comb begin
    all_ok = ((pre_ok | ~pre_used) == '1) && (pre_used != '0);
    any_ok = (pre_ok != '0);
    unique case (cfg.func)
      LTQ_FN_AND: cond = all_ok;
      LTQ_FN_NAND: cond = !all_ok;
      LTQ_FN_OR: cond = any_ok;
      LTQ_FN_NOR: cond = !any_ok;
    endcase
    // goes-false inverts, i.e. swaps AND/NAND and OR/NOR
    if (cfg.goes_false) begin
      cond = !cond;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cond_prev_q <= 1'b0;
      cond_q <= 1'b0;
    end else begin
      cond_prev_q <= cond;
      cond_q <= cond;
    end
  end

  // duration timer in sample clock counts
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_q <= '0;
      timing_q <= 1'b0;
      true_len_q <= '0;
    end else if (!arm) begin
      timer_q <= '0;
      timing_q <= 1'b0;
    end else if (cond && !cond_prev_q) begin
      timer_q <= DW'(1);
      timing_q <= 1'b1;
    end else if (cond && timing_q) begin
      if (timer_q != '1) begin
        timer_q <= timer_q + DW'(1);
      end
    end else if (!cond && timing_q) begin
      timing_q <= 1'b0;
      true_len_q <= timer_q;
    end
  end

  assign state_clk_edge = probes_vld_q && (cfg.state_edge_fall ?
    (probes_q[CHAN_N-1] && !probes[CHAN_N-1]) :
    (!probes_q[CHAN_N-1] && probes[CHAN_N-1]));

  ltq_sh_window #(
    .W(SW)
  ) u_window (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .setup_wr(setup_wr),
    .hold_wr(hold_wr),
    .wr_value(sh_wr_value),
    .setup_q(setup_q),
    .hold_q(hold_q)
  );

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      setup_out_q <= '0;
      hold_out_q <= '0;
    end else begin
      setup_out_q <= setup_q;
      hold_out_q <= hold_q;
    end
  end

  assign sh_clk_edge = probes_vld_q && (cfg.sh_edge_fall ?
    (probes_q[cfg.clk_src] && !probes[cfg.clk_src]) :
    (!probes_q[cfg.clk_src] && probes[cfg.clk_src]));
  assign data_edge = probes_vld_q &&
    probes_q[cfg.data_src] != probes[cfg.data_src];

  // ages of the last data transition and last clock edge, saturating
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      since_data_q <= '1;
      since_clk_q <= '1;
      clk_seen_q <= 1'b0;
    end else if (!arm) begin
      since_data_q <= '1;
      since_clk_q <= '1;
      clk_seen_q <= 1'b0;
    end else begin
      if (data_edge) begin
        since_data_q <= '0;
      end else if (since_data_q != '1) begin
        since_data_q <= since_data_q + SW'(1);
      end
      if (sh_clk_edge) begin
        since_clk_q <= '0;
        clk_seen_q <= 1'b1;
      end else if (since_clk_q != '1) begin
        since_clk_q <= since_clk_q + SW'(1);
      end
    end
  end

  // window is [edge - setup, edge + hold]; signed bounds skew it
  always_comb begin
    sh_hit = 1'b0;
    // data before (or at) the clock edge: age d means time -(d+1)
    if (sh_clk_edge && (data_edge || since_data_q != '1)) begin
      if (data_edge) begin
        sh_hit = (setup_q >= 0) && (hold_q >= 0);
      end else begin
        sh_hit = ($signed({1'b0, since_data_q}) + 1 <= setup_q) &&
          (-($signed({1'b0, since_data_q}) + 1) <= hold_q);
      end
    end
    // data after the clock edge, at +since_clk+1
    if (data_edge && clk_seen_q && !sh_clk_edge && since_clk_q != '1) begin
      if (($signed({1'b0, since_clk_q}) + 1 <= hold_q) &&
          (-($signed({1'b0, since_clk_q}) + 1) <= setup_q)) begin
        sh_hit = 1'b1;
      end
    end
  end

  always_comb begin
    trig_d = 1'b0;
    unique case (cfg.trig_class)
      LTQ_CLASS_PATTERN: begin
        unique case (cfg.qual)
          LTQ_QUAL_NONE: trig_d = cond && !cond_prev_q;
          LTQ_QUAL_LESS: trig_d = !cond && timing_q &&
            (timer_q < cfg.dur_limit);
          LTQ_QUAL_MORE: trig_d = !cond && timing_q &&
            (timer_q > cfg.dur_limit);
          default: trig_d = 1'b0;
        endcase
      end
      LTQ_CLASS_STATE: trig_d = state_clk_edge && cond;
      // late data hits report at data time, still marked against that edge
      LTQ_CLASS_SETUP_HOLD: trig_d = sh_hit &&
        (cfg.data_src != cfg.clk_src);
      default: trig_d = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= trig_d && arm;
    end
  end

endmodule : ltq_trigger

// ===== testbench/ltq_cut_model.sv
// stand-in for the circuit under test: drives the four probe lines
// assumes the bench updates the pattern away from the sampling edge
`timescale 1ns/1ps
module ltq_cut_model (
  input wire logic [3:0] pat,
  output logic p1,
  output logic p2,
  output logic p3,
  output logic p4
);
  // thresholded levels, no glitches between bench updates
  assign {p4, p3, p2, p1} = pat;
endmodule : ltq_cut_model

// ===== testbench/ltq_monitor.sv
// port checker for ltq_trigger
// assumes cfg only changes while disarmed
`timescale 1ns/1ps
module ltq_monitor
  import ltq_pkg::*;
#(
  parameter int DW = DUR_W,
  parameter int SW = SH_W
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic arm,
  input wire ltq_cfg_type cfg,
  input wire logic setup_wr,
  input wire logic hold_wr,
  input wire logic signed [SW-1:0] sh_wr_value,
  input wire logic probe_input_4,
  input wire logic trig_q,
  input wire logic [DW-1:0] true_len_q,
  input wire logic cond_q,
  input wire logic signed [SW-1:0] setup_out_q,
  input wire logic signed [SW-1:0] hold_out_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_arm_gate: assert property (!arm ##1 !arm |-> !trig_q)
    else $error("trigger while disarmed");
  a_trig_pulse: assert property (trig_q |=> !trig_q)
    else $error("trigger longer than one cycle");
  a_sum_min: assert property ($past(arst_n) && $past(arst_n, 2)
    |-> int'(setup_out_q) + int'(hold_out_q) >= MIN_WINDOW_CYC)
    else $error("setup plus hold below minimum");
  a_setup_kept: assert property (
    setup_wr ##1 !(setup_wr || hold_wr) [*2]
    |=> setup_out_q == $past(sh_wr_value, 3))
    else $error("setup write not kept");
  a_hold_kept: assert property (
    hold_wr && !setup_wr ##1 !(setup_wr || hold_wr) [*2]
    |=> hold_out_q == $past(sh_wr_value, 3))
    else $error("hold write not kept");
  a_less_len: assert property (trig_q && cfg.qual == LTQ_QUAL_LESS
    && cfg.trig_class == LTQ_CLASS_PATTERN
    |-> !cond_q && true_len_q < cfg.dur_limit)
    else $error("less-than trigger with long run");
  a_more_len: assert property (trig_q && cfg.qual == LTQ_QUAL_MORE
    && cfg.trig_class == LTQ_CLASS_PATTERN
    |-> !cond_q && true_len_q > cfg.dur_limit)
    else $error("more-than trigger with short run");
  a_rise_trig: assert property (trig_q && !cfg.goes_false
    && cfg.qual == LTQ_QUAL_NONE && cfg.trig_class == LTQ_CLASS_PATTERN
    |-> $rose(cond_q))
    else $error("pattern trigger without condition rise");
  a_state_edge: assert property (trig_q
    && cfg.trig_class == LTQ_CLASS_STATE
    |-> $past(probe_input_4) != cfg.state_edge_fall
    && $past(probe_input_4, 2) == cfg.state_edge_fall)
    else $error("state trigger without clock edge");
  a_same_src: assert property (
    (cfg.trig_class == LTQ_CLASS_SETUP_HOLD
    && cfg.data_src == cfg.clk_src) [*2] |-> !trig_q)
    else $error("trigger with shared data and clock");
endmodule : ltq_monitor

bind ltq_trigger ltq_monitor #(.DW(DW), .SW(SW)) ltq_monitor_inst (
  .sys_clk, .arst_n, .arm, .cfg, .setup_wr, .hold_wr, .sh_wr_value,
  .probe_input_4, .trig_q, .true_len_q, .cond_q, .setup_out_q, .hold_out_q
);

// ===== testbench/ltq_trigger_tb.sv
// self-checking bench for ltq_trigger against a cycle model
// assumes all inputs change on the falling edge of sys_clk
`timescale 1ns/1ps
module ltq_trigger_tb
  import ltq_pkg::*;
;
  logic sys_clk = 0, arst_n = 0, arm = 0, swr = 0, hwr = 0;
  logic signed [SH_W-1:0] wv = '0, su_q, ho_q;
  ltq_cfg_type cfg = '0;
  logic [3:0] pat = 4'h0;
  logic p1, p2, p3, p4, trig_q, cond_q, pc = 0, p4p = 0;
  logic tm = 0, etrig = 0;
  logic [DUR_W-1:0] len_q;
  logic [31:0] rnd = 85991;
  int error_cnt = 0, comparisons = 0, run = 0, elen = 0;
  always #5 sys_clk = ~sys_clk;
  ltq_cut_model ltq_cut_model_inst (.pat, .p1, .p2, .p3, .p4);
  ltq_trigger ltq_trigger_inst (.sys_clk, .arst_n, .arm, .cfg,
    .setup_wr(swr), .hold_wr(hwr), .sh_wr_value(wv),
    .probe_input_1(p1), .probe_input_2(p2), .probe_input_3(p3),
    .probe_input_4(p4), .trig_q, .true_len_q(len_q), .cond_q,
    .setup_out_q(su_q), .hold_out_q(ho_q));
  function automatic logic [31:0] nxt(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : nxt
  function automatic logic fn(ltq_cfg_type c, logic [3:0] v, int n);
    logic any, all, used;
    any = 0;
    all = 1;
    used = 0;
    for (int i = 0; i < n; i++) begin
      if (c.pre[i] != LTQ_PRE_DONT_CARE) begin
        used = 1;
        if (v[i] == (c.pre[i] == LTQ_PRE_HIGH)) any = 1;
        else all = 0;
      end
    end
    // bit 0 of the function picks the inverted form, goes-false swaps it
    // and with nothing selected never holds
    return (c.func[1] ? any : all && used) ^ c.func[0] ^ c.goes_false;
  endfunction : fn
  always @(posedge sys_clk) begin : mdl
    logic c, hit;
    c = fn(cfg, pat, cfg.trig_class == LTQ_CLASS_STATE ? 3 : 4);
    hit = cfg.qual == LTQ_QUAL_NONE ? c && !pc : !c && tm
      && (cfg.qual == LTQ_QUAL_MORE ? run > cfg.dur_limit
      : run < cfg.dur_limit);
    if (cfg.trig_class == LTQ_CLASS_STATE)
      hit = p4 != p4p && p4 != cfg.state_edge_fall && c;
    elen = run;
    // timing starts only on a rise seen while armed
    if (!arm) begin
      tm = 0;
      run = 0;
    end else if (c && !pc) begin
      tm = 1;
      run = 1;
    end else if (c && tm) begin
      run++;
    end else if (!c) begin
      tm = 0;
    end
    etrig = arm && hit;
    pc = c;
    p4p = p4;
  end
  task automatic chk(logic [31:0] a, logic [31:0] e);
    comparisons++;
    if (a !== e) begin
      error_cnt++;
      $display("Error t=%0t got %0h exp %0h", $time, a, e);
    end
  endtask : chk
  always @(negedge sys_clk) begin
    if (arst_n && cfg.trig_class != LTQ_CLASS_SETUP_HOLD) begin
      chk(trig_q, etrig);
      chk(cond_q, pc);
      if (etrig && cfg.qual != LTQ_QUAL_NONE) chk(len_q, elen);
    end
  end
  task automatic cyc(int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  task automatic wr(logic s, logic signed [SH_W-1:0] v);
    swr = s;
    hwr = !s;
    wv = v;
    cyc(1);
  endtask : wr
  task automatic st();
    swr = 0;
    hwr = 0;
    cyc(3);
  endtask : st
  task automatic rnd_run(ltq_class_type k, ltq_qual_type q, ltq_func_type f);
    repeat (3) begin
      arm = 0;
      cyc(2);
      rnd = nxt(rnd);
      cfg.trig_class = k;
      cfg.qual = q;
      cfg.func = f;
      cfg.goes_false = q == LTQ_QUAL_NONE && rnd[2];
      cfg.state_edge_fall = rnd[3];
      cfg.dur_limit = 24'(rnd[5:4] + 2);
      for (int i = 1; i < 4; i++)
        cfg.pre[i] = ltq_pre_type'(rnd[7+2*i +: 2] % 3);
      cfg.pre[0] = ltq_pre_type'(1 + rnd[6]);
      cyc(1);
      arm = 1;
      repeat (40) begin
        rnd = nxt(rnd);
        if (rnd[4]) pat[rnd[1:0]] = rnd[2];
        cyc(1);
      end
    end
  endtask : rnd_run
  // d: data move in cycles relative to the clock edge, later is positive
  task automatic sh(logic e, logic [1:0] cs, int d, logic exp);
    logic got;
    arm = 0;
    cyc(2);
    cfg.trig_class = LTQ_CLASS_SETUP_HOLD;
    cfg.data_src = DATA_SRC_RST;
    cfg.clk_src = cs;
    cfg.sh_edge_fall = e;
    pat = {2'h0, e, 1'b0};
    cyc(3);
    arm = 1;
    got = 0;
    for (int k = -7; k < 6; k++) begin
      if (k == d) pat[0] = 1;
      if (k == 0) pat[1] = !e;
      cyc(1);
      got = got | trig_q;
    end
    chk(got, exp);
  endtask : sh
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    #100us;
    error_cnt++;
    end_of_test();
  end
  initial begin
    cyc(8);
    arst_n = 1;
    cyc(3);
    chk(su_q, 1);
    chk(ho_q, 0);
    wr(1, -1);
    st();
    chk(su_q, -1);
    chk(ho_q, 2);
    wr(0, 0);
    st();
    chk(su_q, 1);
    wr(1, 3);
    wr(0, 1);
    st();
    chk(su_q, 3);
    chk(ho_q, 1);
    for (int f = 0; f < 4; f++) begin
      rnd_run(LTQ_CLASS_PATTERN, LTQ_QUAL_NONE, ltq_func_type'(f));
      rnd_run(LTQ_CLASS_PATTERN, LTQ_QUAL_LESS, ltq_func_type'(f));
      rnd_run(LTQ_CLASS_PATTERN, LTQ_QUAL_MORE, ltq_func_type'(f));
      rnd_run(LTQ_CLASS_STATE, LTQ_QUAL_NONE, ltq_func_type'(f));
    end
    // window is setup 3 before to hold 1 after the clock edge
    sh(0, CLK_SRC_RST, -3, 1);
    sh(0, CLK_SRC_RST, -4, 0);
    sh(1, CLK_SRC_RST, 0, 1);
    sh(0, CLK_SRC_RST, 1, 1);
    sh(1, CLK_SRC_RST, 2, 0);
    sh(0, 2'h0, -1, 0);
    wr(1, -1);
    st();
    chk(ho_q, 2);
    // window now lies wholly after the edge, 1 to 2 cycles
    sh(0, CLK_SRC_RST, 2, 1);
    sh(0, CLK_SRC_RST, 0, 0);
    sh(1, CLK_SRC_RST, 3, 0);
    end_of_test();
  end
endmodule : ltq_trigger_tb
